// ===== design/sbc_pkg.sv
// constants for the skip, branch, call and add decoder
package sbc_pkg;
  localparam int          PC_W          = 21;
  localparam logic [20:0] PC_STEP       = 21'h00_0002;
  localparam logic [20:0] CALL_RET_OFS  = 21'h00_0004;
  localparam logic [20:0] PC_RESET      = 21'h00_0000;
  localparam logic [3:0]  OP_SKIP_CLEAR = 4'hB;
  localparam logic [3:0]  OP_SKIP_SET   = 4'hA;
  localparam logic [5:0]  OP_ADD_FILE   = 6'h09;
  localparam logic [7:0]  OP_BRANCH_Z   = 8'hE0;
  localparam logic [6:0]  OP_CALL_1     = 7'h76;
  localparam logic [3:0]  OP_WORD2      = 4'hF;
  localparam int          BIT_D         = 9;
  localparam int          BIT_A         = 8;
  localparam int          BIT_S         = 8;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_DC       = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_OV       = 3;
  localparam int          FLAG_N        = 4;
  localparam logic [3:0]  ACCESS_BANK_LO = 4'h0;
  localparam logic [3:0]  ACCESS_BANK_HI = 4'hF;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
  localparam logic [1:0]  Q_LAST        = 2'h3;
  localparam int          CLOCK_MHZ     = 40;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_CALL2 = 2'b10
  } exec_state_t;
endpackage

// ===== design/sbc_bank_addr.sv
// file-register address builder: access bank or bank pointer
`timescale 1ns/1ps
module sbc_bank_addr
  import sbc_pkg::*;
(
  input  wire logic [7:0]  file_addr_i,
  input  wire logic        bank_sel_i,
  input  wire logic [3:0]  bank_select_pointer_i,
  output logic      [11:0] full_addr_o
);
  always_comb begin
    if (bank_sel_i) begin
      full_addr_o = {bank_select_pointer_i, file_addr_i}; // [RL5]
    end else if (file_addr_i < ACCESS_SPLIT) begin
      full_addr_o = {ACCESS_BANK_LO, file_addr_i}; // [RL5]
    end else begin
      full_addr_o = {ACCESS_BANK_HI, file_addr_i}; // [RL5]
    end
  end
endmodule // sbc_bank_addr

// ===== design/skip_branch_call_decode.sv
// execution unit for bit skips, branch on zero, call and add-to-file
`timescale 1ns/1ps
// What this block does
// RL1 - skip-if-clear with the bit zero turns the prefetched word into a no-op, taking two cycles.
// RL2 - a taken skip over a two-word instruction takes three cycles, both extra ones no-ops.
// RL3 - skip-if-set skips when the chosen bit reads one, else completes in one cycle.
// RL4 - a taken skip-if-set replaces the prefetched word by a no-op cycle, two cycles in all.
// RL5 - bank bit low selects the access bank, high selects the bank pointer's bank.
// RL6 - branch on zero with the flag set loads pc plus two plus twice the signed offset in two cycles.
// RL7 - a call first pushes pc plus four onto the return stack.
// RL8 - a call with the fast bit set copies accumulator, flags and bank pointer to shadows.
// RL9 - a call takes two words and two cycles and loads the 20-bit target into pc bits 20 to 1.
// RL10 - each sequential word advances the pc by two with bit 0 held at zero.
// RL11 - add-to-file writes the sum to accumulator or file by d and updates all five flags.
module skip_branch_call_decode
  import sbc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic [15:0]       instr_i,
  input  wire logic              instr_valid_i,
  input  wire logic [7:0]        file_rdata_i,
  input  wire logic [3:0]        bank_select_pointer_i,
  output logic      [11:0]       file_addr_o,
  output logic                   file_we_o,
  output logic      [7:0]        file_wdata_o,
  output logic      [PC_W-1:0]   pc_o,
  output logic                   push_o,
  output logic      [PC_W-1:0]   stack_top_o,
  output logic      [7:0]        working_accumulator_o,
  output logic      [4:0]        flags_o,
  output logic      [7:0]        accum_shadow_o,
  output logic      [4:0]        flags_shadow_o,
  output logic      [3:0]        bank_pointer_shadow_o,
  output logic                   nop_cycle_o,
  output logic      [1:0]        q_phase_o
);
  // ============================================================
  // decode
  exec_state_t state;
  exec_state_t next_state;
  logic [1:0]  q;
  logic        cyc_end;
  logic        is_clr;
  logic        is_set;
  logic        is_add;
  logic        is_bz;
  logic        is_call;
  logic        bit_val;
  logic        skip;
  logic [7:0]  sum;
  logic        c7;
  logic        c3;
  logic [7:0]  call_lo;
  logic        call_fast;
  logic [PC_W-1:0] pc_next_seq;
  logic [PC_W-1:0] bz_target;
  logic        call_ok;
  logic        branch_flush;

  function automatic logic is_two_word(input logic [15:0] w);
    return w[15:9] == OP_CALL_1;
  endfunction

  assign cyc_end = clk_en_i && (q == Q_LAST);
  wire   exec_ok = (state == ST_EXEC) && instr_valid_i;
  assign is_clr  = exec_ok && (instr_i[15:12] == OP_SKIP_CLEAR);
  assign is_set  = exec_ok && (instr_i[15:12] == OP_SKIP_SET);
  assign is_add  = exec_ok && (instr_i[15:10] == OP_ADD_FILE);
  assign is_bz   = exec_ok && (instr_i[15:8] == OP_BRANCH_Z);
  assign is_call = exec_ok && is_two_word(instr_i);
  assign bit_val = file_rdata_i[instr_i[11:9]];
  assign skip    = (is_clr && !bit_val) || (is_set && bit_val); // [RL1] [RL3]
  assign pc_next_seq = pc_o + PC_STEP; // [RL10]
  assign bz_target   = pc_o + PC_STEP + {{12{instr_i[7]}}, instr_i[7:0], 1'b0}; // [RL6]
  assign {c7, sum}   = {1'b0, working_accumulator_o} + {1'b0, file_rdata_i};
  assign c3          = ({1'b0, working_accumulator_o[3:0]} + {1'b0, file_rdata_i[3:0]}) > 5'h0F;

  sbc_bank_addr u_bank (
    .file_addr_i           (instr_i[7:0]),
    .bank_sel_i            (instr_i[BIT_A]),
    .bank_select_pointer_i (bank_select_pointer_i),
    .full_addr_o           (file_addr_o)
  );

  // ============================================================
  // quarter-cycle phase counter
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= 2'h0;
    end else if (clk_en_i) begin
      q <= q + 2'h1;
    end
  end
  assign q_phase_o = q;

  // ============================================================
  // cycle sequencer
  always_comb begin
    next_state = ST_EXEC;
    case (state)
      ST_EXEC: begin
        if (skip || (is_bz && flags_o[FLAG_Z])) begin
          next_state = ST_FLUSH; // [RL1] [RL4] [RL6]
        end else if (is_call) begin
          next_state = ST_CALL2; // [RL9]
        end
      end
      ST_FLUSH: begin
        // skipped call: its second word needs one more no-op cycle
        if (!branch_flush && instr_valid_i && is_two_word(instr_i)) begin
          next_state = ST_CALL2; // [RL2]
        end
      end
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_EXEC;
    end else if (cyc_end) begin
      state <= next_state;
    end
  end
  assign nop_cycle_o = (state != ST_EXEC);

  // ============================================================
  // program counter and stack push
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_o <= PC_RESET;
    end else if (cyc_end) begin
      if (is_bz && flags_o[FLAG_Z]) begin
        pc_o <= {bz_target[PC_W-1:1], 1'b0}; // [RL6]
      end else if (state == ST_CALL2 && call_ok) begin
        pc_o <= {instr_i[11:0], call_lo, 1'b0}; // [RL9]
      end else if (state == ST_FLUSH && branch_flush) begin
        pc_o <= pc_o; // [RL6]
      end else begin
        pc_o <= {pc_next_seq[PC_W-1:1], 1'b0}; // [RL10]
      end
    end
  end

  // branch no-op cycle fetches the target, so pc holds
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      branch_flush <= 1'b0;
    end else if (cyc_end) begin
      branch_flush <= is_bz && flags_o[FLAG_Z]; // [RL6]
    end
  end

  // call second word accepted only when first word executed
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      call_ok   <= 1'b0;
      call_lo   <= 8'h00;
      call_fast <= 1'b0;
    end else if (cyc_end) begin
      call_ok   <= is_call;
      if (is_call) begin
        call_lo   <= instr_i[7:0];
        call_fast <= instr_i[BIT_S];
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      push_o      <= 1'b0;
      stack_top_o <= PC_RESET;
    end else if (clk_en_i) begin
      push_o <= cyc_end && is_call;
      if (cyc_end && is_call) begin
        // pc here still holds the call's address
        stack_top_o <= pc_o + CALL_RET_OFS; // [RL7]
      end
    end
  end

  // ============================================================
  // shadows on fast call
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      accum_shadow_o        <= 8'h00;
      flags_shadow_o        <= 5'h00;
      bank_pointer_shadow_o <= 4'h0;
    end else if (cyc_end && is_call && instr_i[BIT_S]) begin
      accum_shadow_o        <= working_accumulator_o; // [RL8]
      flags_shadow_o        <= flags_o; // [RL8]
      bank_pointer_shadow_o <= bank_select_pointer_i; // [RL8]
    end
  end

  // ============================================================
  // add accumulator to file
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      working_accumulator_o <= 8'h00;
      flags_o               <= 5'h00;
    end else if (cyc_end && is_add) begin
      if (!instr_i[BIT_D]) begin
        working_accumulator_o <= sum; // [RL11]
      end
      flags_o[FLAG_C]  <= c7; // [RL11]
      flags_o[FLAG_DC] <= c3;
      flags_o[FLAG_Z]  <= (sum == 8'h00);
      flags_o[FLAG_N]  <= sum[7];
      flags_o[FLAG_OV] <= (working_accumulator_o[7] == file_rdata_i[7]) && (sum[7] != file_rdata_i[7]);
    end
  end
  assign file_we_o = cyc_end && is_add && instr_i[BIT_D]; // [RL11]
  always_comb begin
    file_wdata_o = sum;
  end

  // ============================================================
  // checks
  sequence s_skip_taken;
    cyc_end && skip;
  endsequence

  sequence s_call_word2;
    cyc_end && state == ST_CALL2 && call_ok;
  endsequence

  AST_CLR_SKIP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL1]
    (cyc_end && is_clr && !bit_val) |=> nop_cycle_o)
    else $error("skip-if-clear did not insert no-op");
  AST_SET_SKIP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL3]
    (cyc_end && is_set && bit_val) |=> state == ST_FLUSH)
    else $error("skip-if-set did not flush");
  AST_SET_NOSKIP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL3]
    (cyc_end && is_set && !bit_val) |=> state == ST_EXEC)
    else $error("untaken skip added a cycle");
  AST_SKIP2: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL2]
    (cyc_end && state == ST_FLUSH && !branch_flush && instr_valid_i && is_two_word(instr_i)) |=> state == ST_CALL2)
    else $error("two-word skip missed third cycle");
  AST_BANK: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL5]
    instr_i[BIT_A] |-> file_addr_o[11:8] == bank_select_pointer_i)
    else $error("bank pointer not used");
  AST_BZ: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL6]
    (cyc_end && is_bz && flags_o[FLAG_Z]) |=> pc_o == {$past(bz_target[PC_W-1:1]), 1'b0})
    else $error("branch target wrong");
  AST_PUSH: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL7]
    (cyc_end && is_call) |=> push_o && stack_top_o == $past(pc_o) + CALL_RET_OFS)
    else $error("call pushed wrong address");
  AST_FAST: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL8]
    (cyc_end && is_call && !instr_i[BIT_S]) |=> $stable(accum_shadow_o))
    else $error("shadow changed without fast bit");
  AST_PC_ALIGN: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL10] [RL9]
    pc_o[0] == 1'b0)
    else $error("pc misaligned");
  AST_SKIP_NOP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL1] [RL4] [RL10]
    s_skip_taken |=> nop_cycle_o && pc_o == $past(pc_o) + PC_STEP)
    else $error("taken skip did not step into a no-op");
  AST_BZ_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL6]
    (cyc_end && state == ST_FLUSH && branch_flush) |=> $stable(pc_o))
    else $error("pc moved during branch no-op");
  AST_CALL_PC: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL9]
    s_call_word2 |=> pc_o[PC_W-1:1] == {$past(instr_i[11:0]), $past(call_lo)})
    else $error("call target not loaded");
  AST_ACC_KEEP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RL11]
    (cyc_end && is_add && instr_i[BIT_D]) |=> $stable(working_accumulator_o))
    else $error("accumulator written for file destination");
endmodule // skip_branch_call_decode

// ===== test/test_skip_branch_call_decode.sv
// self-checking bench for the skip, branch, call and add decoder
`timescale 1ns/1ps
module test_skip_branch_call_decode;
  import sbc_pkg::*;
  typedef struct {logic [3:0] op; logic [2:0] b; logic a; logic [7:0] f; logic [11:0] adr; logic [7:0] v; logic sk;} row_t;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, instr_valid_i = 1'b1;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_pointer_i = 4'h3;
  logic [7:0] file_rdata_i, file_wdata_o, working_accumulator_o, accum_shadow_o;
  logic [11:0] file_addr_o;
  logic file_we_o, push_o, nop_cycle_o;
  logic [PC_W-1:0] pc_o, stack_top_o, p;
  logic [4:0] flags_o, flags_shadow_o;
  logic [3:0] bank_pointer_shadow_o;
  logic [1:0] q_phase_o;
  logic [7:0] mem [0:4095];
  logic n0, n1;
  logic [11:0] ad;
  int mismatches = 0, checks = 0;
  row_t rows [5] = '{
    '{OP_SKIP_CLEAR, 3'd3, 1'b0, 8'h12, 12'h012, 8'h00, 1'b1}, '{OP_SKIP_CLEAR, 3'd3, 1'b0, 8'h12, 12'h012, 8'h08, 1'b0},
    '{OP_SKIP_SET, 3'd7, 1'b1, 8'h10, 12'h310, 8'h80, 1'b1}, '{OP_SKIP_SET, 3'd0, 1'b0, 8'h90, 12'hF90, 8'hFE, 1'b0},
    '{OP_SKIP_SET, 3'd0, 1'b0, 8'h7F, 12'h07F, 8'h01, 1'b1}};
  always #12.5 clock_i = ~clock_i;
  assign file_rdata_i = mem[file_addr_o];
  always @(posedge clock_i) if (file_we_o === 1'b1) mem[file_addr_o] <= file_wdata_o;
  skip_branch_call_decode i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .file_rdata_i(file_rdata_i), .bank_select_pointer_i(bank_select_pointer_i),
    .file_addr_o(file_addr_o), .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .pc_o(pc_o), .push_o(push_o),
    .stack_top_o(stack_top_o), .working_accumulator_o(working_accumulator_o), .flags_o(flags_o),
    .accum_shadow_o(accum_shadow_o), .flags_shadow_o(flags_shadow_o), .bank_pointer_shadow_o(bank_pointer_shadow_o),
    .nop_cycle_o(nop_cycle_o), .q_phase_o(q_phase_o));
  // ==========================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one instruction cycle, sampled just before the executing edge
  task automatic cyc(input logic [15:0] w, output logic nop, output logic [11:0] adr);
    instr_i = w;
    while (q_phase_o !== Q_LAST) @(negedge clock_i);
    nop = nop_cycle_o;
    adr = file_addr_o;
    @(negedge clock_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(25ns * 3000);
    mismatches++;
    report_and_stop;
  end
  // ==========================================
  // tests
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (12) @(negedge clock_i);
    check("pc_rst", pc_o, PC_RESET);
    check("acc_rst", working_accumulator_o, 8'h00);
    check("q_rst", q_phase_o, 2'h0);
    sys_rst_i = 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      mem[rows[i].adr] = rows[i].v;
      p = pc_o;
      cyc({rows[i].op, rows[i].b, rows[i].a, rows[i].f}, n0, ad);
      check("addr", ad, rows[i].adr);
      cyc(16'h0000, n1, ad);
      check("skip_nop", n1, rows[i].sk);
      check("pc_seq", pc_o, p + 2 * PC_STEP);
    end
    $display("test skip table done");
    mem[12'h044] = 8'h01;
    cyc({OP_SKIP_SET, 3'd0, 1'b0, 8'h44}, n0, ad);
    cyc({OP_CALL_1, 1'b0, 8'h00}, n1, ad);
    check("skip2_a", n1, 1'b1);
    cyc({OP_WORD2, 12'h000}, n1, ad);
    check("skip2_b", n1, 1'b1);
    cyc(16'h0000, n1, ad);
    check("skip2_c", n1, 1'b0);
    $display("test two-word skip done");
    mem[12'h021] = 8'h17;
    mem[12'h022] = 8'hC2;
    cyc({OP_ADD_FILE, 1'b0, 1'b0, 8'h20}, n0, ad);
    check("flags_z", flags_o, 5'b00100);
    p = pc_o;
    cyc({OP_BRANCH_Z, 8'hFD}, n0, ad);
    check("bz_pc", pc_o, p + PC_STEP - 21'h00_0006);
    cyc({OP_CALL_1, 1'b0, 8'h00}, n1, ad);
    check("bz_nop", n1, 1'b1);
    check("bz_hold", pc_o, p + PC_STEP - 21'h00_0006);
    cyc({OP_ADD_FILE, 1'b0, 1'b0, 8'h21}, n0, ad);
    p = pc_o;
    cyc({OP_BRANCH_Z, 8'h7F}, n0, ad);
    check("bnz_pc", pc_o, p + PC_STEP);
    cyc({OP_ADD_FILE, 1'b1, 1'b0, 8'h22}, n1, ad);
    check("bnz_nop", n1, 1'b0);
    check("add_mem", mem[12'h022], 8'hD9);
    check("add_acc", working_accumulator_o, 8'h17);
    check("add_flg", flags_o, 5'b10000);
    $display("test branch and add done");
    for (int s = 1; s >= 0; s--) begin
      p = pc_o;
      cyc({OP_CALL_1, 1'(s), 8'hDE}, n0, ad);
      check("ret_adr", stack_top_o, p + CALL_RET_OFS);
      check("push", push_o, 1'b1);
      check("sh_acc", accum_shadow_o, 8'h17);
      check("sh_flg", flags_shadow_o, 5'b10000);
      check("sh_bank", bank_pointer_shadow_o, 4'h3);
      cyc({OP_WORD2, 12'hABC}, n1, ad);
      check("call_nop", n1, 1'b1);
      check("call_pc", pc_o, 21'h15_79BC);
      check("push_end", push_o, 1'b0);
      mem[12'h023] = 8'h01;
      bank_select_pointer_i = 4'h5;
      cyc({OP_ADD_FILE, 1'b0, 1'b0, 8'h23}, n0, ad);
    end
    $display("test call done");
    p = pc_o;
    clk_en_i = 1'b0;
    repeat (8) @(negedge clock_i);
    check("frz_pc", pc_o, p);
    check("frz_q", q_phase_o, 2'h0);
    clk_en_i = 1'b1;
    $display("test clock enable done");
    mem[12'h045] = 8'h01;
    instr_valid_i = 1'b0;
    cyc({OP_SKIP_SET, 3'd0, 1'b0, 8'h45}, n0, ad);
    instr_valid_i = 1'b1;
    cyc(16'h0000, n1, ad);
    check("inv_noskip", n1, 1'b0);
    $display("test invalid word done");
    sys_rst_i = 1'b1;
    @(negedge clock_i);
    check("rst2_pc", pc_o, PC_RESET);
    check("rst2_q", q_phase_o, 2'h0);
    check("rst2_sh", accum_shadow_o, 8'h00);
    sys_rst_i = 1'b0;
    cyc(16'h0000, n0, ad);
    check("rst2_nop", n0, 1'b0);
    check("rst2_seq", pc_o, PC_RESET + PC_STEP);
    $display("test mid-run reset done");
    report_and_stop;
  end
endmodule // test_skip_branch_call_decode
